// ---- pmr_rx_straps.sv ----
// receive pins toward the mac and the straps that share them
// assumes line nibbles arrive on clk_line; pins pass through pads outside
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`default_nettype none
module pmr_rx_straps
  import pmr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clk_line,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // decoded receive stream from the line side, clk_line domain
  input  wire logic [3:0]  lineNibble,
  input  wire logic        lineSym4,
  input  wire logic        lineValid,
  input  wire logic        lineErr,
  output logic             lineTake,
  // receive pins, each as input, output and output enable
  input  wire logic [3:0]  rxDataIn,
  output logic [3:0]       rxDataOut,
  output logic [3:0]       rxDataOe,
  input  wire logic        rxErrIn,
  output logic             rxErrOut,
  output logic             rxErrOe,
  input  wire logic        rxDvIn,
  output logic             rxDvOut,
  output logic             rxDvOe,
  input  wire logic        rxClkIn,
  output logic             rxClkOut,
  output logic             rxClkOe,
  // shared interrupt / transmit error / symbol bit 4 pin
  input  wire logic        sharedIn,
  output logic             irqOutLow,
  output logic             irqOutLowOe,
  // device side
  input  wire logic        irqRequest,
  output logic             txErrOrSymbolBit4,
  output logic [2:0]       opMode,
  output logic             coreRegEnable,
  output logic             strapsReady
);

  // ---------------- pin synchronisers, system domain
  logic [PMR_PIN_COUNT-1:0] pinMeta;
  logic [PMR_PIN_COUNT-1:0] pinSync;
  wire  [PMR_PIN_COUNT-1:0] pinRaw = {sharedIn, rxClkIn, rxDvIn, rxErrIn,
                                      rxDataIn};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  // ---------------- strap capture after reset release
  pmr_state_t state;
  pmr_state_t next_state;
  logic [2:0] settleCnt;
  logic [2:0] strapMode;
  logic       strapIrqSel;
  logic       strapRegOff;
  logic       strapFault;

  wire settleDone = (settleCnt == 3'(PMR_STRAP_SETTLE_CYC - 1));
  wire captureNow = (state == PMR_ST_SETTLE) && settleDone;
  wire running    = (state == PMR_ST_RUN);

  always_comb begin
    case (state)
      PMR_ST_RESET:  next_state = PMR_ST_SETTLE;
      PMR_ST_SETTLE: next_state = settleDone ? PMR_ST_RUN : PMR_ST_SETTLE;
      PMR_ST_RUN:    next_state = PMR_ST_RUN;
      default:       next_state = PMR_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state     <= PMR_ST_RESET;
      settleCnt <= '0;
    end else begin
      state     <= next_state;
      settleCnt <= (state == PMR_ST_SETTLE) ? settleCnt + 3'h1 : 3'h0;
    end
  end

  // straps caught once, when the settle count ends after reset release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strapMode   <= 3'h0;
      strapIrqSel <= 1'b1;
      strapRegOff <= 1'b0;
      strapFault  <= 1'b0;
    end else if (captureNow) begin
      strapMode   <= pinSync[PMR_PIN_RXD_LSB +: 3];
      strapIrqSel <= pinSync[PMR_PIN_RXD_LSB + 3];
      strapRegOff <= pinSync[PMR_PIN_RXCLK];
      strapFault  <= pinSync[PMR_PIN_RXER] |
                     pinSync[PMR_PIN_RXDV];
    end
  end

  assign opMode        = strapMode;
  assign strapsReady   = running;
  assign coreRegEnable = running && !strapRegOff;

  // ---------------- shared interrupt / transmit error pin
  logic irqDrive;
  logic txSide;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irqDrive <= 1'b0;
      txSide   <= 1'b0;
    end else begin
      irqDrive <= running && strapIrqSel && irqRequest;
      txSide   <= running && !strapIrqSel &&
                  pinSync[PMR_PIN_SHARED];
    end
  end

  // open drain: pulls low only while an interrupt is pending
  assign irqOutLow         = 1'b0;
  assign irqOutLowOe       = irqDrive;
  assign txErrOrSymbolBit4 = txSide;

  // ---------------- apb slave
  logic [2:0] ctrl;
  wire setupPhase = psel && !penable;
  wire accessWr   = psel && penable && pwrite;
  wire hitCtrl    = (paddr == PMR_CTRL_ADDR);
  wire hitStatus  = (paddr == PMR_STATUS_ADDR);
  wire hitAny     = hitCtrl || hitStatus;
  wire [31:0] statusWord = {25'h0, strapFault, running, strapRegOff,
                            strapIrqSel, strapMode};
  wire [31:0] readMux = hitCtrl   ? {29'h0, ctrl} :
                        hitStatus ? statusWord    : 32'h0;

  assign pready = 1'b1;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl    <= PMR_CTRL_RESET;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      if (setupPhase) begin
        prdata  <= pwrite ? 32'h0 : readMux;
        pslverr <= !hitAny;
      end
      if (accessWr && hitCtrl) begin
        ctrl <= pwdata[2:0];
      end
    end
  end

  // ---------------- crossing of quasi-static controls into clk_line
  logic [3:0] ctlMeta;
  logic [3:0] ctlSync;
  logic [3:0] ctlPrev;
  logic [3:0] ctlLine;
  wire  [3:0] ctlRaw = {running, ctrl};
  // word taken only after two equal samples, so bits never mix
  wire        ctlSteady = (ctlSync == ctlPrev);

  always_ff @(posedge clk_line or negedge rst_b) begin
    if (!rst_b) begin
      ctlMeta <= '0;
      ctlSync <= '0;
      ctlPrev <= '0;
      ctlLine <= '0;
    end else begin
      ctlMeta <= ctlRaw;
      ctlSync <= ctlMeta;
      ctlPrev <= ctlSync;
      ctlLine <= ctlSteady ? ctlSync : ctlLine;
    end
  end

  wire lnSpeed100 = ctlLine[PMR_CTRL_SPEED100_BIT];
  wire lnSymbol   = ctlLine[PMR_CTRL_SYMBOL_BIT];
  wire lnReduced  = ctlLine[PMR_CTRL_REDUCED_BIT];
  wire lnRun      = ctlLine[3];

  // ---------------- receive clock divider, line domain
  logic [4:0] divCnt;
  logic       rxClkReg;
  wire  [4:0] halfLast = lnSpeed100 ? 5'(PMR_HALF_100_CYC - 1)
                                    : 5'(PMR_HALF_10_CYC - 1);
  wire        halfEnd  = (divCnt >= halfLast);
  // data move as the output clock falls, so the mac samples mid-period
  wire        updTick  = halfEnd && rxClkReg && lnRun;

  always_ff @(posedge clk_line or negedge rst_b) begin
    if (!rst_b) begin
      divCnt   <= 5'h0;
      rxClkReg <= 1'b0;
    end else if (!lnRun) begin
      divCnt   <= 5'h0;
      rxClkReg <= 1'b0;
    end else begin
      divCnt   <= halfEnd ? 5'h0 : divCnt + 5'h1;
      rxClkReg <= halfEnd ? !rxClkReg : rxClkReg;
    end
  end

  // ---------------- receive data registers, line domain
  logic [3:0] rxNib;
  logic       rxDv;
  logic       rxErr;

  always_ff @(posedge clk_line or negedge rst_b) begin
    if (!rst_b) begin
      rxNib <= 4'h0;
      rxDv  <= 1'b0;
      rxErr <= 1'b0;
    end else if (!lnRun) begin
      rxNib <= 4'h0;
      rxDv  <= 1'b0;
      rxErr <= 1'b0;
    end else if (updTick) begin
      rxNib <= lineValid ? lineNibble : 4'h0;
      rxDv  <= lineValid;
      rxErr <= lnSymbol ? lineSym4
                        : (lineValid && lineErr);
    end
  end

  assign lineTake = updTick;

  // ---------------- pin drivers, undriven until straps are held
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rxd
      assign rxDataOut[gi] = rxNib[gi];
      if (gi < 2) begin : g_low
        assign rxDataOe[gi] = lnRun;
      end else begin : g_high
        assign rxDataOe[gi] = lnRun && !lnReduced;
      end
    end
  endgenerate

  assign rxErrOut = rxErr;
  assign rxErrOe  = lnRun;               // driven in reduced mode
  assign rxDvOut  = rxDv;
  assign rxDvOe   = lnRun && !lnReduced;
  assign rxClkOut = rxClkReg;
  assign rxClkOe  = lnRun && !lnReduced;

  // ---------------- assertions
  no_drive_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !running |-> !irqOutLowOe && !coreRegEnable)
    else $error("pins or regulator driven before strap capture");

  strap_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    running && $past(running) |-> $stable(strapMode) && $stable(strapIrqSel))
    else $error("straps changed after capture");

  strap_capture_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    captureNow |=> opMode == $past(pinSync[2:0]) && running)
    else $error("mode straps not taken at capture");

  irq_select_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    running && strapIrqSel && irqRequest |=> irqOutLowOe)
    else $error("interrupt not driven on shared pin");

  tx_select_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !strapIrqSel |=> !irqOutLowOe ##0
      (txErrOrSymbolBit4 == ($past(pinSync[PMR_PIN_SHARED]) && running)))
    else $error("shared pin not used as transmit input");

  regulator_off_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    running |-> coreRegEnable == !strapRegOff)
    else $error("regulator enable disagrees with strap");

  reduced_pins_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    lnReduced |-> rxDataOe[3:2] == 2'b00 && !rxDvOe && !rxClkOe)
    else $error("unused pins driven in reduced mode");

  valid_follow_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    updTick |=> rxDvOut == $past(lineValid) &&
                (rxDataOut == ($past(lineValid) ? $past(lineNibble) : 4'h0)))
    else $error("valid or nibble not presented with line data");

  symbol_bit_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    updTick && lnSymbol |=> rxErrOut == $past(lineSym4))
    else $error("symbol bit 4 missing on error pin");

  error_flag_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    updTick && !lnSymbol && lineValid && lineErr |=> rxErrOut)
    else $error("receive error not raised");

  clk_period_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    lnRun && lnSpeed100 && $stable(lnSpeed100) && divCnt == 5'h0 |->
      ##1 rxClkOut != $past(rxClkOut))
    else $error("receive clock divider wrong at 100 Mb/s");

  line_idle_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    !lnRun |-> rxDataOe == 4'h0 && !rxErrOe && !rxDvOe && !rxClkOe)
    else $error("receive pins driven before strap capture");

  irqsel_capture_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    captureNow |=> strapIrqSel == $past(pinSync[PMR_PIN_RXD_LSB + 3]))
    else $error("interrupt select strap not taken at capture");

  core_regulator_disable_strap_capture_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    captureNow |=> coreRegEnable == !$past(pinSync[PMR_PIN_RXCLK]))
    else $error("regulator strap not taken at capture");

  irq_release_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !irqRequest |=> !irqOutLowOe)
    else $error("interrupt held without a request");

  data_hold_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    lnRun && !updTick |=>
      $stable(rxDvOut) && $stable(rxDataOut) && $stable(rxErrOut))
    else $error("receive outputs moved between clock periods");

  error_idle_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    updTick && !lnSymbol && !lineValid |=> !rxErrOut)
    else $error("receive error raised outside a frame");

  reduced_err_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    lnRun && lnReduced |-> rxErrOe)
    else $error("error pin dropped in reduced mode");

  clk_hold_a: assert property (
    @(posedge clk_line) disable iff (!rst_b)
    lnRun && divCnt < halfLast |=> $stable(rxClkOut))
    else $error("receive clock moved inside a half period");

endmodule : pmr_rx_straps
`default_nettype wire

// ---- pmr_pkg.sv ----
// constants for the receive pin block and its power-up straps
// assumes a 200 MHz system clock and a 50 MHz recovered line clock
`default_nettype none
package pmr_pkg;
  // apb register map, byte addresses
  localparam logic [11:0] PMR_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] PMR_STATUS_ADDR = 12'h004;
  // control fields
  localparam int PMR_CTRL_SPEED100_BIT = 0;
  localparam int PMR_CTRL_SYMBOL_BIT   = 1;
  localparam int PMR_CTRL_REDUCED_BIT  = 2;
  localparam logic [2:0] PMR_CTRL_RESET = 3'h1;
  // status fields
  localparam int PMR_STAT_MODE_LSB    = 0;
  localparam int PMR_STAT_IRQSEL_BIT  = 3;
  localparam int PMR_STAT_CORE_REGULATOR_DISABLE_STRAP_BIT  = 4;
  localparam int PMR_STAT_CAPTURE_BIT = 5;
  localparam int PMR_STAT_FAULT_BIT   = 6;
  // strap pin positions inside the synchronised pin vector
  localparam int PMR_PIN_RXD_LSB  = 0;
  localparam int PMR_PIN_RXER     = 4;
  localparam int PMR_PIN_RXDV     = 5;
  localparam int PMR_PIN_RXCLK    = 6;
  localparam int PMR_PIN_SHARED   = 7;
  localparam int PMR_PIN_COUNT    = 8;
  // timing
  localparam int PMR_SYS_PERIOD_NS   = 5;
  localparam int PMR_STRAP_SETTLE_NS = 20;
  localparam int PMR_STRAP_SETTLE_CYC =
    (PMR_STRAP_SETTLE_NS + PMR_SYS_PERIOD_NS - 1) / PMR_SYS_PERIOD_NS;
  localparam int PMR_LINK_CLK_KHZ  = 50000;
  localparam int PMR_RXCLK_100_KHZ = 25000;
  localparam int PMR_RXCLK_10_KHZ  = 2500;
  localparam int PMR_HALF_100_CYC  =
    PMR_LINK_CLK_KHZ / (2 * PMR_RXCLK_100_KHZ);
  localparam int PMR_HALF_10_CYC   =
    PMR_LINK_CLK_KHZ / (2 * PMR_RXCLK_10_KHZ);
  // strap capture sequencer, gray along the path
  typedef enum logic [1:0] {
    PMR_ST_RESET  = 2'b00,
    PMR_ST_SETTLE = 2'b01,
    PMR_ST_RUN    = 2'b11
  } pmr_state_t;
endpackage : pmr_pkg
`default_nettype wire

// ---- pmr_mac_model.sv ----
// mac-side model: pin pulls, strap levels, nibble capture at rx clock
// assumes pins resolve from the block's out and enable pairs
`default_nettype none
module pmr_mac_model (
  input  wire logic       clk_line,
  input  wire logic [3:0] strapD,
  input  wire logic       strapClk,
  input  wire logic [3:0] dOut,
  input  wire logic [3:0] dOe,
  input  wire logic       eOut,
  input  wire logic       eOe,
  input  wire logic       vOut,
  input  wire logic       vOe,
  input  wire logic       cOut,
  input  wire logic       cOe,
  output logic      [3:0] dPin,
  output logic            ePin,
  output logic            vPin,
  output logic            cPin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] got[$];
  int         per = 0;
  int         cnt = 0;
  logic       prev = 1'b0;
  // strap resistors hold undriven lines
  assign dPin = (dOe & dOut) | (~dOe & strapD);
  assign ePin = eOe & eOut;
  assign vPin = vOe & vOut;
  assign cPin = cOe ? cOut : strapClk;
  // nibble taken on rising rx clock
  always @(posedge cPin)
    if (vPin === 1'b1) got.push_back({ePin, vPin, dPin});
  // rx clock period in line cycles
  always @(posedge clk_line) begin
    prev <= cPin;
    if (cPin && !prev) begin
      per <= cnt;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : pmr_mac_model
`default_nettype wire

// ---- pmr_rx_straps_bench.sv ----
// bench for the receive pins and their power-up straps
// assumes pmr_pkg, the block and pmr_mac_model are compiled first
`default_nettype none
module pmr_rx_straps_bench import pmr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 0, clk_line = 0, rst_b = 0;
  logic        psel = 0, penable = 0, pwrite = 0, se;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, lineTake, sym4 = 0;
  logic        lineValid = 0, lineErr = 0, strapClk = 0, sharedDrv = 0;
  logic [3:0]  lineNibble = '0, strapD = '0, dOut, dOe, dPin;
  logic        eOut, eOe, vOut, vOe, cOut, cOe, ePin, vPin, cPin;
  logic        irqOutLow, irqOutLowOe, irqRequest = 0, txErr;
  logic        coreRegEnable, strapsReady;
  logic [2:0]  opMode;
  logic [6:0]  lineQ[$];
  int          err_count = 0, comparisons = 0;
  wire         sharedPin = irqOutLowOe ? irqOutLow : sharedDrv;
  always #2.5 clk_sys = ~clk_sys;
  always #16 clk_line = ~clk_line;
  pmr_rx_straps u_dut (.clk_sys, .rst_b, .clk_line, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .lineNibble,
    .lineSym4(sym4), .lineValid, .lineErr, .lineTake, .rxDataIn(dPin),
    .rxDataOut(dOut), .rxDataOe(dOe), .rxErrIn(ePin), .rxErrOut(eOut),
    .rxErrOe(eOe), .rxDvIn(vPin), .rxDvOut(vOut), .rxDvOe(vOe),
    .rxClkIn(cPin), .rxClkOut(cOut), .rxClkOe(cOe), .sharedIn(sharedPin),
    .irqOutLow, .irqOutLowOe, .irqRequest, .txErrOrSymbolBit4(txErr),
    .opMode, .coreRegEnable, .strapsReady);
  pmr_mac_model u_mac (.clk_line, .strapD, .strapClk, .dOut, .dOe, .eOut,
    .eOe, .vOut, .vOe, .cOut, .cOe, .dPin, .ePin, .vPin, .cPin);
  // line side presents the next item once the current one is taken
  always @(posedge clk_line)
    if (lineTake === 1'b1) begin
      if (lineQ.size() > 0) {sym4, lineValid, lineErr, lineNibble} <=
        lineQ.pop_front();
      else {lineValid, lineErr} <= 2'b00;
    end
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task give_up;
    err_count++;
    $display("ERROR %0t wait ran out", $time);
    finish_test();
  endtask : give_up
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (++n > 50) give_up();
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task do_reset(input logic [3:0] d, input logic c);
    int n;
    n = 0;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    strapD <= d;
    strapClk <= c;
    repeat (16) @(posedge clk_sys);
    chk({dOe, eOe, vOe, cOe, strapsReady, coreRegEnable}, 0);
    rst_b <= 1'b1;
    while (cOe !== 1'b1) begin
      @(posedge clk_sys);
      if (++n > 200) give_up();
    end
  endtask : do_reset
  task frame(input logic sym, input int p);
    int n;
    n = 0;
    u_mac.got.delete();
    for (int i = 0; i < 16; i++)
      lineQ.push_back({i[0], 1'b1, i == 9, i[3:0]});
    while (u_mac.got.size() < 16) begin
      @(posedge clk_sys);
      if (++n > 8000) give_up();
    end
    repeat (300) @(posedge clk_sys);
    chk(u_mac.got.size(), 16);
    for (int i = 0; i < 16; i++)
      chk(u_mac.got[i], {sym ? i[0] : i==9, 1'b1, i[3:0]});
    chk(u_mac.per, p);
    $display("frame test done");
  endtask : frame
  initial begin
    do_reset(4'hD, 1'b0);
    apb(1'b0, PMR_STATUS_ADDR, 0);
    chk(rd, 32'h0000_002D);
    chk({opMode, coreRegEnable, strapsReady}, {3'h5, 2'b11});
    apb(1'b0, PMR_CTRL_ADDR, 0);
    chk(rd, {29'h0, PMR_CTRL_RESET});
    apb(1'b0, 12'h0FC, 0);
    chk({se, rd[30:0]}, 32'h8000_0000);
    irqRequest <= 1'b1;
    sharedDrv <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({irqOutLowOe, sharedPin, txErr}, 3'h4);
    irqRequest <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(irqOutLowOe, 0);
    $display("strap and interrupt test done");
    frame(1'b0, 2);
    apb(1'b1, PMR_CTRL_ADDR, 32'h0);
    frame(1'b0, 20);
    apb(1'b1, PMR_CTRL_ADDR, 32'h3);
    frame(1'b1, 2);
    apb(1'b1, PMR_CTRL_ADDR, 32'h5);
    apb(1'b0, PMR_CTRL_ADDR, 0);
    chk(rd, 32'h0000_0005);
    repeat (60) @(posedge clk_sys);
    chk({dOe, eOe, vOe, cOe}, 7'h1C);
    $display("reduced mode test done");
    do_reset(4'h2, 1'b1);
    chk({opMode, coreRegEnable}, {3'h2, 1'b0});
    apb(1'b0, PMR_STATUS_ADDR, 0);
    chk(rd, 32'h0000_0032);
    irqRequest <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({irqOutLowOe, txErr}, 2'b01);
    sharedDrv <= 1'b0;
    irqRequest <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk(txErr, 0);
    $display("transmit error select test done");
    finish_test();
  end
endmodule : pmr_rx_straps_bench
`default_nettype wire
